// ==== io_space_cpu.sv ====
module io_space_cpu (
	// clock and reset
	input  wire logic        ref_clk_in,
	input  wire logic        rst_b_in,
	// device side
	io_bus_if.cpu            bus,
	// command side
	input  wire logic        cmd_valid_in,
	input  wire logic [3:0]  cmd_kind_in,
	input  wire logic [15:0] cmd_addr_in,
	input  wire logic [23:0] cmd_data_in,
	input  wire logic [7:0]  cmd_resv_mask_in,
	input  wire logic [2:0]  cmd_bit_in,
	output logic             cmd_ready_out,
	output logic             done_out,
	output logic             error_out,
	output logic [23:0]      result_out,
	output logic             irq_mask_out
);
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ISSUE,
		ST_WAIT
	} cpu_state_e;

	cpu_state_e             state_reg;
	io_space_pkg::cmd_e     kind_reg;
	logic [15:0]            addr_reg;
	logic [23:0]            data_reg;
	logic [7:0]             mask_reg;
	logic [2:0]             bit_reg;
	logic [1:0]             idx_reg;
	logic [1:0]             last_reg;
	logic [23:0]            result_reg;
	logic                   done_reg;
	logic                   error_reg;
	logic                   is_wr;
	logic                   is_rd;
	logic                   is_io;
	io_space_pkg::bit_op_e  bop;
	io_space_pkg::cmd_e     new_kind;
	logic [1:0]             new_last;
	logic                   legal;

	assign new_kind = io_space_pkg::cmd_e'(cmd_kind_in);

	// byte count and legality of a new command
	always_comb begin
		new_last = 2'd0;
		legal    = 1'b1;
		case (new_kind)
			io_space_pkg::CMD_RD16, io_space_pkg::CMD_WR16: new_last = 2'd1;
			io_space_pkg::CMD_RD24, io_space_pkg::CMD_WR24: new_last = 2'd2;
			default: new_last = 2'd0;
		endcase
		case (new_kind)
			io_space_pkg::CMD_IN, io_space_pkg::CMD_OUT:
				legal = (cmd_addr_in <= io_space_pkg::IO_LAST);
			io_space_pkg::CMD_SET_BIT, io_space_pkg::CMD_CLR_BIT, io_space_pkg::CMD_TEST_BIT:
				legal = (cmd_addr_in <= io_space_pkg::BIT_LAST);
			io_space_pkg::CMD_WR8, io_space_pkg::CMD_WR16, io_space_pkg::CMD_WR24:
				legal = io_space_pkg::addr_assigned(cmd_addr_in) &&
					io_space_pkg::addr_assigned(cmd_addr_in + {14'h0000, new_last});
			default: legal = 1'b1;
		endcase
	end

	// request lines decoded from the held command
	always_comb begin
		is_wr = 1'b0;
		is_rd = 1'b0;
		is_io = 1'b0;
		bop   = io_space_pkg::BIT_NONE;
		case (kind_reg)
			io_space_pkg::CMD_WR8, io_space_pkg::CMD_WR16, io_space_pkg::CMD_WR24: is_wr = 1'b1;
			io_space_pkg::CMD_OUT: begin
				is_wr = 1'b1;
				is_io = 1'b1;
			end
			io_space_pkg::CMD_IN: begin
				is_rd = 1'b1;
				is_io = 1'b1;
			end
			io_space_pkg::CMD_SET_BIT: begin
				is_io = 1'b1;
				bop   = io_space_pkg::BIT_SET;
			end
			io_space_pkg::CMD_CLR_BIT: begin
				is_io = 1'b1;
				bop   = io_space_pkg::BIT_CLEAR;
			end
			io_space_pkg::CMD_TEST_BIT: begin
				is_io = 1'b1;
				bop   = io_space_pkg::BIT_TEST;
			end
			default: is_rd = 1'b1;
		endcase
	end

	// sequencer: one byte per issue, lowest address first
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_reg <= ST_IDLE;
			idx_reg   <= 2'd0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					idx_reg <= 2'd0;
					if (cmd_valid_in && legal) begin
						state_reg <= ST_ISSUE;
					end
				end
				ST_ISSUE: state_reg <= ST_WAIT;
				ST_WAIT: begin
					if (bus.ack) begin
						if (idx_reg == last_reg) begin
							state_reg <= ST_IDLE;
						end else begin
							idx_reg   <= idx_reg + 2'd1;
							state_reg <= ST_ISSUE;
						end
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// command capture
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			kind_reg <= io_space_pkg::CMD_RD8;
			addr_reg <= 16'h0000;
			data_reg <= 24'h000000;
			mask_reg <= 8'h00;
			bit_reg  <= 3'h0;
			last_reg <= 2'd0;
		end else if (state_reg == ST_IDLE && cmd_valid_in) begin
			kind_reg <= new_kind;
			addr_reg <= cmd_addr_in;
			data_reg <= cmd_data_in;
			mask_reg <= cmd_resv_mask_in;
			bit_reg  <= cmd_bit_in;
			last_reg <= new_last;
		end
	end

	// result collection and completion pulses
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			result_reg <= 24'h000000;
			done_reg   <= 1'b0;
			error_reg  <= 1'b0;
		end else begin
			done_reg  <= 1'b0;
			error_reg <= 1'b0;
			if (state_reg == ST_IDLE && cmd_valid_in) begin
				result_reg <= 24'h000000;
				if (!legal) begin
					done_reg  <= 1'b1;
					error_reg <= 1'b1;
				end
			end else if (state_reg == ST_WAIT && bus.ack) begin
				if (bop == io_space_pkg::BIT_TEST) begin
					result_reg[0] <= bus.skip;
				end else if (is_rd) begin
					result_reg[idx_reg*8 +: 8] <= bus.rdata;
				end
				done_reg <= (idx_reg == last_reg);
			end
		end
	end

	// bus drive, strobes only in the issue cycle
	assign bus.addr    = addr_reg + {14'h0000, idx_reg};
	assign bus.wdata   = data_reg[idx_reg*8 +: 8] & ~mask_reg;
	assign bus.wr      = (state_reg == ST_ISSUE) && is_wr;
	assign bus.rd      = (state_reg == ST_ISSUE) && is_rd;
	assign bus.io_op   = is_io;
	assign bus.bit_op  = (state_reg == ST_ISSUE) ? bop : io_space_pkg::BIT_NONE;
	assign bus.bit_sel = bit_reg;

	assign cmd_ready_out = (state_reg == ST_IDLE);
	assign irq_mask_out  = (state_reg != ST_IDLE) && (last_reg != 2'd0);
	assign done_out      = done_reg;
	assign error_out     = error_reg;
	assign result_out    = result_reg;
endmodule

// ==== io_space_pkg.sv ====
// How it works
// - io addresses 0x00..0x3f reach single-cycle io
// - 0x00..0x1f allow bit set, clear, skip tests
// - 0x0040..0x103f reached only by load/store
// - writer zeroes reserved bits
// - writer never writes unassigned io addresses
// - wide access is separate byte transfers
// - wide registers sit behind staging latch
// - wide write: low byte first, high last
// - low byte write lands in staging latch
// - high write loads high, copies latch low
// - wide read: low byte first, high last
// - low read returns live, snapshots high byte
// - high read returns staging latch contents
// - writer masks interrupts across wide sequence
// - or isr saves and restores staging latch
// - 24-bit registers use two staging latches
// - 24-bit: write msb last, read lsb first
package io_space_pkg;
	localparam logic [15:0] IO_FIRST     = 16'h0000;
	localparam logic [15:0] BIT_LAST     = 16'h001f;
	localparam logic [15:0] IO_LAST      = 16'h003f;
	localparam logic [15:0] EXT_FIRST    = 16'h0040;
	localparam logic [15:0] EXT_LAST     = 16'h103f;
	localparam int          IO_DEPTH     = 64;
	// example peripheral placed in the extended range
	localparam logic [15:0] PERIPH_BASE  = 16'h0a00;
	localparam logic [2:0]  OFS_CNT_L    = 3'h0;
	localparam logic [2:0]  OFS_CNT_H    = 3'h1;
	localparam logic [2:0]  OFS_PER_B0   = 3'h2;
	localparam logic [2:0]  OFS_PER_B1   = 3'h3;
	localparam logic [2:0]  OFS_PER_B2   = 3'h4;
	localparam logic [2:0]  OFS_TEMP0    = 3'h5;
	localparam logic [2:0]  OFS_TEMP1    = 3'h6;
	localparam logic [2:0]  OFS_LAST     = 3'h6;
	localparam logic [7:0]  TEMP_RESET   = 8'h00;
	localparam logic [15:0] CNT_RESET    = 16'h0000;
	localparam logic [23:0] PER_RESET    = 24'h000000;
	localparam logic [7:0]  UNMAPPED_RD  = 8'h00;

	typedef enum logic [1:0] {
		BIT_NONE,
		BIT_SET,
		BIT_CLEAR,
		BIT_TEST
	} bit_op_e;

	typedef enum logic [3:0] {
		CMD_RD8,
		CMD_WR8,
		CMD_RD16,
		CMD_WR16,
		CMD_RD24,
		CMD_WR24,
		CMD_SET_BIT,
		CMD_CLR_BIT,
		CMD_TEST_BIT,
		CMD_IN,
		CMD_OUT
	} cmd_e;

	// true when an address belongs to an assigned register
	function automatic logic addr_assigned(input logic [15:0] a);
		addr_assigned = (a <= IO_LAST) ||
			((a >= PERIPH_BASE) && (a <= (PERIPH_BASE + {13'h0000, OFS_LAST})));
	endfunction
endpackage

// ==== io_bus_if.sv ====
interface io_bus_if;
	logic [15:0]                addr;
	logic [7:0]                 wdata;
	logic                       rd;
	logic                       wr;
	logic                       io_op;
	io_space_pkg::bit_op_e      bit_op;
	logic [2:0]                 bit_sel;
	logic [7:0]                 rdata;
	logic                       ack;
	logic                       skip;

	modport dev (
		input  addr, wdata, rd, wr, io_op, bit_op, bit_sel,
		output rdata, ack, skip
	);
	modport cpu (
		output addr, wdata, rd, wr, io_op, bit_op, bit_sel,
		input  rdata, ack, skip
	);
endinterface

// ==== io_space_dev.sv ====
module io_space_dev (
	// clock and reset
	input  wire logic        ref_clk_in,
	input  wire logic        rst_b_in,
	// cpu side
	io_bus_if.dev            bus,
	// peripheral user side
	input  wire logic        count_en_in,
	output logic [15:0]      count_out,
	output logic [23:0]      period_out
);
	logic [7:0]  io_mem_reg [0:io_space_pkg::IO_DEPTH-1];
	logic [15:0] count_reg;
	logic [23:0] period_reg;
	logic [7:0]  temp0_reg;
	logic [7:0]  temp1_reg;
	logic [7:0]  rdata_reg;
	logic        ack_reg;
	logic        skip_reg;
	logic        in_io;
	logic        in_bit;
	logic        in_ext;
	logic        per_hit;
	logic [2:0]  ofs;
	logic        access;
	logic        bit_ok;
	logic        mem_wr;
	logic        per_wr;
	logic        per_rd;
	logic [7:0]  rd_next;

	// address decode
	assign in_io   = (bus.addr <= io_space_pkg::IO_LAST);
	assign in_bit  = (bus.addr <= io_space_pkg::BIT_LAST);
	assign in_ext  = (bus.addr >= io_space_pkg::EXT_FIRST) &&
		(bus.addr <= io_space_pkg::EXT_LAST) && !bus.io_op;
	assign per_hit = in_ext && (bus.addr[15:3] == io_space_pkg::PERIPH_BASE[15:3]);
	assign ofs     = bus.addr[2:0];
	assign bit_ok  = bus.io_op && in_bit && (bus.bit_op != io_space_pkg::BIT_NONE);
	assign access  = bus.rd || bus.wr || (bus.bit_op != io_space_pkg::BIT_NONE);
	assign mem_wr  = bus.wr && in_io && (bus.bit_op == io_space_pkg::BIT_NONE);
	assign per_wr  = bus.wr && per_hit;
	assign per_rd  = bus.rd && per_hit;

	// io space bytes and single-bit set and clear
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			for (int i = 0; i < io_space_pkg::IO_DEPTH; i++) begin
				io_mem_reg[i] <= 8'h00;
			end
		end else if (mem_wr) begin
			io_mem_reg[bus.addr[5:0]] <= bus.wdata;
		end else if (bit_ok && bus.bit_op == io_space_pkg::BIT_SET) begin
			io_mem_reg[bus.addr[5:0]][bus.bit_sel] <= 1'b1;
		end else if (bit_ok && bus.bit_op == io_space_pkg::BIT_CLEAR) begin
			io_mem_reg[bus.addr[5:0]][bus.bit_sel] <= 1'b0;
		end
	end

	// shared staging latches, held until next low access, middle byte write or direct write
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			temp0_reg <= io_space_pkg::TEMP_RESET;
			temp1_reg <= io_space_pkg::TEMP_RESET;
		end else if (per_wr) begin
			case (ofs)
				io_space_pkg::OFS_CNT_L:  temp0_reg <= bus.wdata;
				io_space_pkg::OFS_PER_B0: temp0_reg <= bus.wdata;
				io_space_pkg::OFS_PER_B1: temp1_reg <= bus.wdata;
				io_space_pkg::OFS_TEMP0:  temp0_reg <= bus.wdata;
				io_space_pkg::OFS_TEMP1:  temp1_reg <= bus.wdata;
				default: ;
			endcase
		end else if (per_rd) begin
			case (ofs)
				io_space_pkg::OFS_CNT_L: temp0_reg <= count_reg[15:8];
				io_space_pkg::OFS_PER_B0: begin
					temp0_reg <= period_reg[15:8];
					temp1_reg <= period_reg[23:16];
				end
				default: ;
			endcase
		end
	end

	// 16-bit counter, loaded atomically on the high byte write
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			count_reg <= io_space_pkg::CNT_RESET;
		end else if (per_wr && ofs == io_space_pkg::OFS_CNT_H) begin
			count_reg <= {bus.wdata, temp0_reg};
		end else if (count_en_in) begin
			count_reg <= count_reg + 16'h0001;
		end
	end

	// 24-bit register, loaded atomically on the msb write
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			period_reg <= io_space_pkg::PER_RESET;
		end else if (per_wr && ofs == io_space_pkg::OFS_PER_B2) begin
			period_reg <= {bus.wdata, temp1_reg, temp0_reg};
		end
	end

	// read data selection
	always_comb begin
		rd_next = io_space_pkg::UNMAPPED_RD;
		if (in_io) begin
			rd_next = io_mem_reg[bus.addr[5:0]];
		end else if (per_hit) begin
			case (ofs)
				io_space_pkg::OFS_CNT_L:  rd_next = count_reg[7:0];
				io_space_pkg::OFS_CNT_H:  rd_next = temp0_reg;
				io_space_pkg::OFS_PER_B0: rd_next = period_reg[7:0];
				io_space_pkg::OFS_PER_B1: rd_next = temp0_reg;
				io_space_pkg::OFS_PER_B2: rd_next = temp1_reg;
				io_space_pkg::OFS_TEMP0:  rd_next = temp0_reg;
				io_space_pkg::OFS_TEMP1:  rd_next = temp1_reg;
				default:                  rd_next = io_space_pkg::UNMAPPED_RD;
			endcase
		end
	end

	// answer one cycle after each access
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rdata_reg <= 8'h00;
			ack_reg   <= 1'b0;
			skip_reg  <= 1'b0;
		end else begin
			ack_reg   <= access;
			rdata_reg <= bus.rd ? rd_next : 8'h00;
			skip_reg  <= bit_ok && (bus.bit_op == io_space_pkg::BIT_TEST) &&
				io_mem_reg[bus.addr[5:0]][bus.bit_sel];
		end
	end

	assign bus.rdata  = rdata_reg;
	assign bus.ack    = ack_reg;
	assign bus.skip   = skip_reg;
	assign count_out  = count_reg;
	assign period_out = period_reg;
endmodule

// ==== io_space_props.sv ====
module io_space_props (
	// clock and reset
	input wire logic                  ref_clk_in,
	input wire logic                  rst_b_in,
	// bus signals between the two ends
	input wire logic [15:0]           addr,
	input wire logic [7:0]            wdata,
	input wire logic                  rd,
	input wire logic                  wr,
	input wire logic                  io_op,
	input wire io_space_pkg::bit_op_e bit_op,
	input wire logic [2:0]            bit_sel,
	input wire logic [7:0]            rdata,
	input wire logic                  ack,
	input wire logic                  skip
);
	localparam logic [15:0] A_CNT_L = io_space_pkg::PERIPH_BASE + 16'h0000;
	localparam logic [15:0] A_CNT_H = io_space_pkg::PERIPH_BASE + 16'h0001;
	localparam logic [15:0] A_PER_0 = io_space_pkg::PERIPH_BASE + 16'h0002;
	localparam logic [15:0] A_PER_1 = io_space_pkg::PERIPH_BASE + 16'h0003;
	localparam logic [15:0] A_PER_2 = io_space_pkg::PERIPH_BASE + 16'h0004;
	localparam logic [15:0] A_TEMP0 = io_space_pkg::PERIPH_BASE + 16'h0005;
	localparam logic [15:0] A_TOP   = io_space_pkg::PERIPH_BASE + 16'h0006;

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_b_in);

	logic       req;
	logic       wr_lo;
	logic       rd_lo;
	logic       wr_p1;
	logic [7:0] temp0_reg;
	logic       temp0_ok_reg;

	// strobe decode used by the properties
	assign req   = rd || wr || (bit_op != io_space_pkg::BIT_NONE);
	assign wr_lo = wr && (addr == A_CNT_L);
	assign rd_lo = rd && (addr == A_CNT_L);
	assign wr_p1 = wr && (addr == A_PER_1);

	// first staging latch value while it is known from bus traffic alone
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			temp0_reg    <= io_space_pkg::TEMP_RESET;
			temp0_ok_reg <= 1'b1;
		end else if (wr && (addr == A_CNT_L || addr == A_PER_0 || addr == A_TEMP0)) begin
			temp0_reg    <= wdata;
			temp0_ok_reg <= 1'b1;
		end else if (rd && (addr == A_CNT_L || addr == A_PER_0)) begin
			temp0_ok_reg <= 1'b0;
		end
	end

	property p_ack_follows; req |=> ack; endproperty
	a_ack_follows: assert property (p_ack_follows) else $error("no ack after request");
	property p_ack_cause; ack |-> $past(req); endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	property p_wr_rdata; wr |=> ack && rdata == 8'h00; endproperty
	a_wr_rdata: assert property (p_wr_rdata) else $error("write answered with data");
	property p_unmapped;
		rd && addr > io_space_pkg::IO_LAST && (addr < A_CNT_L || addr > A_TOP)
			|=> rdata == io_space_pkg::UNMAPPED_RD;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_temp_read;
		rd && temp0_ok_reg && (addr == A_TEMP0 || addr == A_CNT_H) |=> rdata == $past(temp0_reg);
	endproperty
	a_temp_read: assert property (p_temp_read) else $error("staging latch read wrong");
	property p_skip_cause;
		skip |-> $past(bit_op) == io_space_pkg::BIT_TEST && $past(io_op);
	endproperty
	a_skip_cause: assert property (p_skip_cause) else $error("skip without bit test");
	property p_bit_range;
		bit_op != io_space_pkg::BIT_NONE |-> io_op && addr <= io_space_pkg::BIT_LAST;
	endproperty
	a_bit_range: assert property (p_bit_range) else $error("bit op out of range");
	property p_io_range; io_op && (rd || wr) |-> addr <= io_space_pkg::IO_LAST; endproperty
	a_io_range: assert property (p_io_range) else $error("in or out above io range");
	property p_wr_order; wr && addr == A_CNT_H |-> $past(wr_lo, 2); endproperty
	a_wr_order: assert property (p_wr_order) else $error("high write not after low");
	property p_rd_order; rd && addr == A_CNT_H |-> $past(rd_lo, 2); endproperty
	a_rd_order: assert property (p_rd_order) else $error("high read not after low");
	property p_wr24; wr && addr == A_PER_2 |-> $past(wr_p1, 2); endproperty
	a_wr24: assert property (p_wr24) else $error("top byte not written last");
endmodule

// ==== tb.sv ====
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; \
	$display("CHECK FAILED at %0t got %h exp %h", $time, (a), (b)); end end
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        ref_clk_in = 1'b0;
	logic        rst_b_in = 1'b0;
	logic        count_en_in = 1'b0;
	logic        cmd_valid_in = 1'b0;
	logic [3:0]  cmd_kind_in = 4'h0;
	logic [15:0] cmd_addr_in = 16'h0000;
	logic [23:0] cmd_data_in = 24'h000000;
	logic [7:0]  cmd_resv_mask_in = 8'h00;
	logic [2:0]  cmd_bit_in = 3'h0;
	logic        cmd_ready_out, done_out, error_out, irq_mask_out, err_seen, mask_seen;
	logic [23:0] result_out, period_out, res;
	logic [15:0] count_out;
	int          fails = 0;
	int          compares = 0;
	localparam logic [15:0] BASE = io_space_pkg::PERIPH_BASE;

	io_bus_if bus_if();
	// 10 MHz clock
	always #50 ref_clk_in = ~ref_clk_in;

	io_space_dev u_io_space_dev (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .bus(bus_if),
		.count_en_in(count_en_in), .count_out(count_out), .period_out(period_out));
	io_space_cpu u_io_space_cpu (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .bus(bus_if),
		.cmd_valid_in(cmd_valid_in), .cmd_kind_in(cmd_kind_in), .cmd_addr_in(cmd_addr_in),
		.cmd_data_in(cmd_data_in), .cmd_resv_mask_in(cmd_resv_mask_in), .cmd_bit_in(cmd_bit_in),
		.cmd_ready_out(cmd_ready_out), .done_out(done_out), .error_out(error_out),
		.result_out(result_out), .irq_mask_out(irq_mask_out));
	io_space_props u_io_space_props (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
		.addr(bus_if.addr), .wdata(bus_if.wdata), .rd(bus_if.rd), .wr(bus_if.wr),
		.io_op(bus_if.io_op), .bit_op(bus_if.bit_op), .bit_sel(bus_if.bit_sel),
		.rdata(bus_if.rdata), .ack(bus_if.ack), .skip(bus_if.skip));

	// verdict and end of run
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// one command, waits for done under a bound
	task automatic run(input io_space_pkg::cmd_e k, input logic [15:0] a,
		input logic [23:0] d, input logic [2:0] b);
		int n;
		@(negedge ref_clk_in);
		cmd_kind_in = k;
		cmd_addr_in = a;
		cmd_data_in = d;
		cmd_bit_in = b;
		cmd_valid_in = 1'b1;
		@(negedge ref_clk_in);
		cmd_valid_in = 1'b0;
		mask_seen = irq_mask_out;
		for (n = 0; n < 40 && done_out !== 1'b1; n++) begin
			@(negedge ref_clk_in);
			mask_seen = mask_seen | irq_mask_out;
		end
		if (n == 40) begin
			fails++;
			close_out();
		end
		err_seen = error_out;
		res = result_out;
	endtask

	// io range and refusals
	task automatic t_io();
		run(io_space_pkg::CMD_OUT, 16'h003f, 24'h00005a, 3'h0);
		run(io_space_pkg::CMD_IN, 16'h003f, 24'h000000, 3'h0);
		`CHK(res, 24'h00005a)
		run(io_space_pkg::CMD_OUT, 16'h0040, 24'h000011, 3'h0);
		`CHK(err_seen, 1'b1)
		run(io_space_pkg::CMD_RD8, 16'h0040, 24'h000000, 3'h0);
		`CHK(res, 24'h000000)
		run(io_space_pkg::CMD_WR8, 16'h0100, 24'h000001, 3'h0);
		`CHK(err_seen, 1'b1)
		$display("test io done");
	endtask

	// bit set, clear and test
	task automatic t_bits();
		run(io_space_pkg::CMD_OUT, 16'h001f, 24'h000000, 3'h0);
		run(io_space_pkg::CMD_SET_BIT, 16'h001f, 24'h000000, 3'h7);
		run(io_space_pkg::CMD_TEST_BIT, 16'h001f, 24'h000000, 3'h7);
		`CHK(res[0], 1'b1)
		run(io_space_pkg::CMD_IN, 16'h001f, 24'h000000, 3'h0);
		`CHK(res, 24'h000080)
		run(io_space_pkg::CMD_CLR_BIT, 16'h001f, 24'h000000, 3'h7);
		run(io_space_pkg::CMD_TEST_BIT, 16'h001f, 24'h000000, 3'h7);
		`CHK(res[0], 1'b0)
		run(io_space_pkg::CMD_SET_BIT, 16'h0020, 24'h000000, 3'h0);
		`CHK(err_seen, 1'b1)
		$display("test bits done");
	endtask

	// 16-bit counter through the staging latch
	task automatic t_wide16();
		run(io_space_pkg::CMD_RD8, BASE + 16'h0005, 24'h000000, 3'h0);
		`CHK(res, 24'h000000)
		run(io_space_pkg::CMD_WR16, BASE, 24'h0001fe, 3'h0);
		`CHK(count_out, 16'h01fe)
		`CHK(mask_seen, 1'b1)
		count_en_in = 1'b1;
		repeat (10) @(negedge ref_clk_in);
		count_en_in = 1'b0;
		run(io_space_pkg::CMD_RD16, BASE, 24'h000000, 3'h0);
		`CHK(res, 24'h000208)
		run(io_space_pkg::CMD_WR8, BASE, 24'h0000aa, 3'h0);
		`CHK(count_out, 16'h0208)
		run(io_space_pkg::CMD_RD8, BASE + 16'h0005, 24'h000000, 3'h0);
		`CHK(res, 24'h0000aa)
		run(io_space_pkg::CMD_RD8, BASE, 24'h000000, 3'h0);
		`CHK(res, 24'h000008)
		run(io_space_pkg::CMD_RD8, BASE + 16'h0005, 24'h000000, 3'h0);
		`CHK(res, 24'h000002)
		run(io_space_pkg::CMD_WR8, BASE + 16'h0005, 24'h000055, 3'h0);
		run(io_space_pkg::CMD_RD8, BASE + 16'h0005, 24'h000000, 3'h0);
		`CHK(res, 24'h000055)
		$display("test wide16 done");
	endtask

	// 24-bit register with two latches and reserved bits
	task automatic t_wide24();
		run(io_space_pkg::CMD_WR24, BASE + 16'h0002, 24'habcdef, 3'h0);
		`CHK(period_out, 24'habcdef)
		run(io_space_pkg::CMD_RD24, BASE + 16'h0002, 24'h000000, 3'h0);
		`CHK(res, 24'habcdef)
		run(io_space_pkg::CMD_RD8, BASE + 16'h0006, 24'h000000, 3'h0);
		`CHK(res, 24'h0000ab)
		cmd_resv_mask_in = 8'h0f;
		run(io_space_pkg::CMD_WR24, BASE + 16'h0002, 24'h123456, 3'h0);
		`CHK(period_out, 24'h103050)
		cmd_resv_mask_in = 8'h00;
		$display("test wide24 done");
	endtask

	// service routine saves and restores the first latch, then a reset in mid-run
	task automatic t_restore();
		logic [23:0] saved;
		run(io_space_pkg::CMD_RD8, BASE + 16'h0002, 24'h000000, 3'h0);
		`CHK(res, 24'h000050)
		run(io_space_pkg::CMD_RD8, BASE + 16'h0005, 24'h000000, 3'h0);
		saved = res;
		`CHK(saved, 24'h000030)
		run(io_space_pkg::CMD_RD16, BASE, 24'h000000, 3'h0);
		`CHK(res, 24'h000208)
		run(io_space_pkg::CMD_WR8, BASE + 16'h0005, saved, 3'h0);
		run(io_space_pkg::CMD_RD8, BASE + 16'h0003, 24'h000000, 3'h0);
		`CHK(res, 24'h000030)
		run(io_space_pkg::CMD_RD8, BASE + 16'h0004, 24'h000000, 3'h0);
		`CHK(res, 24'h000010)
		`CHK(cmd_ready_out, 1'b1)
		rst_b_in = 1'b0;
		repeat (2) @(negedge ref_clk_in);
		rst_b_in = 1'b1;
		run(io_space_pkg::CMD_RD8, BASE + 16'h0006, 24'h000000, 3'h0);
		`CHK(res, 24'h000000)
		`CHK(count_out, 16'h0000)
		$display("test restore done");
	endtask

	// reset, then the scenarios
	initial begin
		repeat (20) @(negedge ref_clk_in);
		rst_b_in = 1'b1;
		t_io();
		t_bits();
		t_wide16();
		t_wide24();
		t_restore();
		close_out();
	end
endmodule
